// ### hdl/host_port_defines.vh
// constants for the host microprocessor port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define ADDR_W            16
`define DATA_W            16
`define LOW_BYTE_LSB      0
`define HIGH_BYTE_LSB     8
`define BYTE_W            8
`define MEM_SEL_LSB       12
`define MEM_COUNT         16
`define MEM_WORDS         64
`define MEM_IDX_W         6
`define ACCESS_LAT        2
`define ACK_HIGH_CYCLES   1
`define DATA_RESET_VALUE  16'h0000
`endif

// ### hdl/pin_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] stable_reg;

    // reset value is inactive high for the active-low pins
    always @(posedge clk_sys) begin
        if (rst) begin
            meta_reg   <= {WIDTH{1'b1}};
            stable_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg   <= pin_in;
            stable_reg <= meta_reg;
        end
    end

    assign pin_sync_out = stable_reg;
endmodule // pin_sync

// ### hdl/host_microprocessor_port.v
// host microprocessor port: address decode, data bus, acknowledge and byte lanes
// Overview of operation
// R1: address reaches every internal memory
// R2: port active only while select low
// R3: access needs strobe and select low
// R4: read_not_write picks drive or sample
// R5: mode pin picks async or sync timing
// R6: async: acknowledge driven low on completion
// R7: async: acknowledge high, then released
// R8: async: host holds low byte enable low
// R9: sync: low enable drives lower byte
// R10: sync: shared pin enables upper byte
// R11: reset clears state, floats data outputs
// R12: async: host holds strobe until acknowledge
`timescale 1ns/100ps
`include "host_port_defines.vh"
module host_microprocessor_port #(
    parameter MEM_COUNT  = `MEM_COUNT,
    parameter MEM_WORDS  = `MEM_WORDS,
    parameter ACCESS_LAT = `ACCESS_LAT
) (
    input  wire                clk_sys,
    input  wire                rst,
    input  wire                device_reset_n,
    input  wire                port_select_n,
    input  wire                data_strobe_n,
    input  wire                read_not_write,
    input  wire                sync_mode,
    input  wire                low_byte_enable_n,
    input  wire [`ADDR_W-1:0]  address,
    input  wire [`DATA_W-1:0]  data_in,
    output reg  [`DATA_W-1:0]  data_out,
    output reg  [`DATA_W-1:0]  data_oe,
    input  wire                ack_or_high_byte_pin_in,
    output reg                 ack_or_high_byte_pin_out,
    output reg                 ack_or_high_byte_pin_oe,
    output reg                 busy
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_DONE = 4'h4;
    localparam [3:0] ST_ENDH = 4'h8;
    localparam [7:0] LAT     = ACCESS_LAT;

    // synchronised control pins
    wire [5:0] ctl_sync;
    wire       cs_s;
    wire       ds_s;
    wire       rnw_s;
    wire       mode_s;
    wire       bel_s;
    wire       beh_s;
    wire       dev_rst_s;

    pin_sync #(
        .WIDTH (7)
    ) u_ctl_sync (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .pin_in       ({device_reset_n, port_select_n, data_strobe_n, read_not_write,
                        sync_mode, low_byte_enable_n, ack_or_high_byte_pin_in}),
        .pin_sync_out ({dev_rst_s, ctl_sync})
    );
    assign {cs_s, ds_s, rnw_s, mode_s, bel_s, beh_s} = ctl_sync;

    // address and data pins are sampled twice as well
    reg [`ADDR_W-1:0] addr_meta_reg;
    reg [`ADDR_W-1:0] addr_reg;
    reg [`DATA_W-1:0] din_meta_reg;
    reg [`DATA_W-1:0] din_reg;

    always @(posedge clk_sys) begin
        if (rst) begin
            addr_meta_reg <= {`ADDR_W{1'b0}};
            addr_reg      <= {`ADDR_W{1'b0}};
        end else begin
            addr_meta_reg <= address;
            addr_reg      <= addr_meta_reg;
        end
    end

    // write data settles in the same two stages as the controls
    always @(posedge clk_sys) begin
        if (rst) begin
            din_meta_reg <= `DATA_RESET_VALUE;
            din_reg      <= `DATA_RESET_VALUE;
        end else begin
            din_meta_reg <= data_in;
            din_reg      <= din_meta_reg;
        end
    end

    // R1: memory bank from top bits, word from low bits
    // address bits between the two fields are ignored
    function [9:0] mem_index;
        input [`ADDR_W-1:0]    a;
        reg   [3:0]            bank;
        reg   [`MEM_IDX_W-1:0] word;
        begin
            bank      = a[`MEM_SEL_LSB+3:`MEM_SEL_LSB];
            word      = a[`MEM_IDX_W-1:0];
            mem_index = {bank, word};
        end
    endfunction

    reg [`DATA_W-1:0] mem [0:MEM_COUNT*MEM_WORDS-1];

    wire int_reset = rst | ~dev_rst_s;
    // R2: select low keeps the port alive
    wire selected  = ~cs_s;
    // R3: both strobe and select low
    wire access    = selected & ~ds_s;

    reg [3:0]         state_reg;
    reg [3:0]         state_next;
    reg [7:0]         lat_reg;
    reg [`DATA_W-1:0] rd_reg;

    // qualifiers of the finishing edge, shared by memory, read and drivers
    wire              lat_done  = (lat_reg >= LAT);
    wire              commit    = (state_reg == ST_WAIT) && (state_next == ST_DONE);
    wire              commit_rd = commit & rnw_s;
    wire              commit_wr = commit & ~rnw_s;
    wire              in_done   = (state_reg == ST_DONE);
    wire              in_endh   = (state_reg == ST_ENDH);
    wire              read_hold = in_done & access & rnw_s;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (access) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!access) begin
                    // strobe dropped early: abort, nothing written
                    state_next = ST_IDLE;
                end else if (lat_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                // R12: host ends the cycle after acknowledge
                if (!access) begin
                    state_next = ST_ENDH;
                end
            end
            ST_ENDH: begin
                // one cycle for the acknowledge high step
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // R11: device reset clears the state, counter, read and output registers
    always @(posedge clk_sys) begin
        if (int_reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // latency counter runs only while waiting on the memory
    always @(posedge clk_sys) begin
        if (int_reset) begin
            lat_reg <= 8'h00;
        end else if (state_reg == ST_WAIT) begin
            lat_reg <= lat_reg + 8'h01;
        end else begin
            lat_reg <= 8'h00;
        end
    end

    // read word latched once, at the finishing edge
    always @(posedge clk_sys) begin
        if (int_reset) begin
            rd_reg <= `DATA_RESET_VALUE;
        end else if (commit_rd) begin
            // R4: direction chosen by read_not_write
            rd_reg <= mem[mem_index(addr_reg)];
        end
    end

    // memory array has no reset, too large to clear
    always @(posedge clk_sys) begin
        if (!int_reset && commit_wr) begin
            mem[mem_index(addr_reg)] <= din_reg;
        end
    end

    localparam LANES = `DATA_W / `BYTE_W;

    // lane request per byte lane
    function lane_request;
        input sync_timing;
        input enable_n;
        begin
            if (sync_timing) begin
                lane_request = ~enable_n;
            end else begin
                // R8: async relies on low enable held low
                lane_request = 1'b1;
            end
        end
    endfunction

    wire [LANES-1:0]   lane_enable_n = {beh_s, bel_s};
    wire [LANES-1:0]   lane_want;
    wire [`DATA_W-1:0] oe_next;

    // writes always take the full word; lanes steer reads only
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            // R9: low enable drives lower byte
            // R10: shared pin enables upper byte
            assign lane_want[lane] = lane_request(mode_s, lane_enable_n[lane]);
            assign oe_next[lane*`BYTE_W +: `BYTE_W] = {`BYTE_W{read_hold & lane_want[lane]}};
        end
    endgenerate

    // data_out only matters while data_oe is set
    always @(posedge clk_sys) begin
        if (int_reset) begin
            data_out <= `DATA_RESET_VALUE;
        end else begin
            data_out <= rd_reg;
        end
    end

    // R11: data drivers float in reset
    // enables drop whenever a read is not held
    always @(posedge clk_sys) begin
        if (int_reset) begin
            data_oe <= {`DATA_W{1'b0}};
        end else begin
            data_oe <= oe_next;
        end
    end

    // busy spans the release step as well
    always @(posedge clk_sys) begin
        if (int_reset) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != ST_IDLE);
        end
    end

    // acknowledge pin: level and enable decided together
    reg ack_out_next;
    reg ack_oe_next;

    always @* begin
        ack_out_next = 1'b1;
        ack_oe_next  = 1'b0;
        if (mode_s) begin
            // R5: sync leaves the shared pin an input
            ack_out_next = 1'b1;
            ack_oe_next  = 1'b0;
        end else if (in_done && access) begin
            // R6: acknowledge low on completion
            ack_out_next = 1'b0;
            ack_oe_next  = 1'b1;
        end else if (in_done) begin
            // R7: drive high one cycle before release
            ack_out_next = 1'b1;
            ack_oe_next  = 1'b1;
        end else if (in_endh) begin
            // released after the high cycle; pull-up holds it
            ack_out_next = 1'b1;
            ack_oe_next  = 1'b0;
        end else begin
            ack_out_next = 1'b1;
            ack_oe_next  = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (int_reset) begin
            ack_or_high_byte_pin_out <= 1'b1;
        end else begin
            ack_or_high_byte_pin_out <= ack_out_next;
        end
    end

    // R11: shared pin released in reset
    always @(posedge clk_sys) begin
        if (int_reset) begin
            ack_or_high_byte_pin_oe <= 1'b0;
        end else begin
            ack_or_high_byte_pin_oe <= ack_oe_next;
        end
    end
endmodule // host_microprocessor_port

// ### testbench/host_port_monitor.sv
// checker on the host port pins
`timescale 1ns/100ps
module host_port_monitor (
    input logic        clk_sys,
    input logic        rst,
    input logic        port_select_n,
    input logic        data_strobe_n,
    input logic        read_not_write,
    input logic        sync_mode,
    input logic        low_byte_enable_n,
    input logic [15:0] data_oe,
    input logic        ack_or_high_byte_pin_out,
    input logic        ack_or_high_byte_pin_oe
);
    wire ack_o = ack_or_high_byte_pin_out;
    wire ack_e = ack_or_high_byte_pin_oe;
    wire req   = !data_strobe_n && !port_select_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_floats: assert property (disable iff (1'b0) rst |=> data_oe == 16'h0000 && !ack_e)
        else $error("port drives during reset");
    // six cycles cover the two flop sync and the release steps
    a_idle_select: assert property (port_select_n [*6] |-> data_oe == 16'h0000)
        else $error("data driven while deselected");
    a_strobe_needed: assert property (data_strobe_n [*6] |-> !(ack_e && !ack_o))
        else $error("ack low without strobe");
    a_ack_after_req: assert property ($fell(ack_o) && ack_e |-> $past(req, 4))
        else $error("ack without a request");
    a_ack_full_word: assert property ($fell(ack_o) && ack_e && read_not_write |-> data_oe == 16'hffff)
        else $error("read ack without full drive");
    a_ack_high_first: assert property ($fell(ack_e) |-> $past(ack_o))
        else $error("ack released while low");
    a_sync_pin_input: assert property (sync_mode [*3] |-> !ack_e)
        else $error("shared pin driven in sync mode");
    a_low_lane_off: assert property ((sync_mode && low_byte_enable_n) [*6] |-> data_oe[7:0] == 8'h00)
        else $error("low byte driven while disabled");
endmodule // host_port_monitor
bind host_microprocessor_port host_port_monitor u_mon (.*);

// ### testbench/host_master_model.sv
// host bus master model driving the port pins
`timescale 1ns/100ps
module host_master_model (
    input  logic        clk_sys,
    input  logic        sync_mode,
    input  logic [15:0] data_out,
    input  logic [15:0] data_oe,
    input  logic        ack_or_high_byte_pin_out,
    input  logic        ack_or_high_byte_pin_oe,
    output logic        ack_or_high_byte_pin_in,
    output logic        port_select_n = 1'b1,
    output logic        data_strobe_n = 1'b1,
    output logic        read_not_write = 1'b1,
    output logic        low_byte_enable_n = 1'b0,
    output logic [15:0] address = 16'h0000,
    output logic [15:0] data_in = 16'h0000
);
    logic high_n = 1'b1;
    // released shared pin reads high_n: pull-up level in async, the host's upper byte enable in sync
    assign ack_or_high_byte_pin_in = ack_or_high_byte_pin_oe ? ack_or_high_byte_pin_out : high_n;
    task automatic xfer(input logic [1:0] sel_n, input logic rnw, input logic [1:0] lane_n, input logic [15:0] a, wd,
                        output logic [15:0] rd, oe, output logic seen);
        int n;
        n = 0;
        @(posedge clk_sys);
        #2;
        {port_select_n, data_strobe_n, read_not_write, address, data_in} = {sel_n, rnw, a, wd};
        // async pins low enable, sync takes lanes
        {high_n, low_byte_enable_n} = sync_mode ? lane_n : 2'b10;
        // strobe held until ack, sync waits fixed
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (n < 40 && (sync_mode ? n < 8 : ack_or_high_byte_pin_in !== 1'b0));
        {rd, oe, seen} = {data_out, data_oe, ack_or_high_byte_pin_in === 1'b0};
        #1;
        {port_select_n, data_strobe_n, high_n, data_in} = {3'b111, ~wd};
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // host_master_model

// ### testbench/tb_host_microprocessor_port.sv
// self-checking bench for the host microprocessor port
`timescale 1ns/100ps
module tb_host_microprocessor_port;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        device_reset_n = 1'b1;
    logic        sync_mode = 1'b0;
    logic        port_select_n, data_strobe_n, read_not_write, low_byte_enable_n, busy, seen;
    logic        ack_or_high_byte_pin_in, ack_or_high_byte_pin_out, ack_or_high_byte_pin_oe;
    logic [15:0] address, data_in, data_out, data_oe, rd, oe;
    logic [15:0] adr [4] = '{16'h0000, 16'h503f, 16'ha001, 16'hf03f};
    logic [15:0] mask [3] = '{16'h00ff, 16'hff00, 16'hffff};
    logic [1:0]  lanes [3] = '{2'b10, 2'b01, 2'b00};
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    host_microprocessor_port u_dut (.*);
    host_master_model u_host (.*);
    // hang guard well above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic check(input string name, input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_async();
        foreach (adr[i]) u_host.xfer(2'b00, 1'b0, 2'b00, adr[i], adr[i] ^ 16'h5a5a, rd, oe, seen);
        foreach (adr[i]) begin
            u_host.xfer(2'b00, 1'b1, 2'b00, adr[i], 16'h0000, rd, oe, seen);
            check("read", rd, adr[i] ^ 16'h5a5a);
            check("drive", oe, 16'hffff);
            check("ack_seen", {15'h0, seen}, 16'h0001);
        end
    endtask
    task automatic t_refused();
        u_host.xfer(2'b10, 1'b1, 2'b00, 16'h503f, 16'h0000, rd, oe, seen);
        check("deselected", oe, 16'h0000);
        check("no_ack", {15'h0, seen}, 16'h0000);
        u_host.xfer(2'b01, 1'b0, 2'b00, 16'h503f, 16'h1234, rd, oe, seen);
        u_host.xfer(2'b00, 1'b1, 2'b00, 16'h503f, 16'h0000, rd, oe, seen);
        check("kept", rd, 16'h0a65);
    endtask
    task automatic t_sync();
        #2;
        device_reset_n = 1'b0;
        // mode moves only while held in reset
        sync_mode = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check("dev_reset", data_oe, 16'h0000);
        #1;
        device_reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        u_host.xfer(2'b00, 1'b0, 2'b00, 16'ha001, 16'hc3e1, rd, oe, seen);
        foreach (lanes[i]) begin
            u_host.xfer(2'b00, 1'b1, lanes[i], 16'ha001, 16'h0000, rd, oe, seen);
            check("lanes", oe, mask[i]);
            check("lane_data", rd & mask[i], 16'hc3e1 & mask[i]);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        check("reset_oe", data_oe, 16'h0000);
        check("reset_busy", {15'h0, busy}, 16'h0000);
        repeat (3) @(posedge clk_sys);
        t_async();
        t_refused();
        t_sync();
        conclude();
    end
endmodule // tb_host_microprocessor_port
